// File: bench/adc_sequencer_fifo_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module adc_sequencer_fifo_controller_tb;
    import asfc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic        ext_trig, adc_sclk, adc_sdo, adc_frame, adc_conv, mux_in_sel, adc_diff, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  mux_addr;
    logic [1:0]  adc_range, last_rng;
    logic [15:0] code;
    logic [3:0]  last_ch;
    logic        last_diff;
    int          n_conv, n0, cycles;
    int          miscompares = 0;
    int          samples_checked = 0;

    asfc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trig(ext_trig), .adc_sclk(adc_sclk), .adc_sdo(adc_sdo),
        .adc_frame(adc_frame), .adc_conv(adc_conv), .mux_addr(mux_addr),
        .mux_in_sel(mux_in_sel), .adc_diff(adc_diff), .adc_range(adc_range), .irq(irq));
    asfc_conv_model i_conv (.pclk(pclk), .adc_conv(adc_conv), .mux_addr(mux_addr),
        .mux_in_sel(mux_in_sel), .adc_diff(adc_diff), .adc_range(adc_range), .code(code),
        .adc_sclk(adc_sclk), .adc_sdo(adc_sdo), .adc_frame(adc_frame), .last_ch(last_ch),
        .last_rng(last_rng), .last_diff(last_diff), .n_conv(n_conv));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask

    // Polls the fill level at most 6000 times; the check after the loop catches a level never reached
    task automatic wait_cnt(input logic [31:0] n);
        for (int i = 0; i < 6000; i++) begin
            apb(1'b0, ADDR_FIFO_COUNT, 32'h0);
            if (q === n)
                break;
        end
        `CHK(q, n)
    endtask

    task automatic sw_conv(input logic [31:0] n);
        wr(ADDR_CMD, 32'h1);
        wait_cnt(n);
    endtask

    initial begin
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_trig = 1'b0;
        code = 16'hffff;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_RATE, 32'h0000_07cf);
        rd_chk(ADDR_THRESH, 32'h0000_0400);
        rd_chk(ADDR_IRQ_EN, 32'h0);
        apb(1'b0, 8'h2c, 32'h0);
        `CHK(err_q, 1'b1)
        wr(ADDR_RANGE, 32'hc000_0400);
        wr(ADDR_CHAN, 32'h55);
        wr(ADDR_CTRL, 32'h1);
        sw_conv(32'd1);
        code = 16'h1234;
        sw_conv(32'd2);
        `CHK(last_ch, 4'd5)
        `CHK(last_rng, RNG_U10)
        `CHK(n_conv, 2)
        rd_chk(ADDR_FIFO_DATA, 32'h0000_ffff);
        rd_chk(ADDR_FIFO_DATA, 32'h0000_1234);
        code = 16'h0001;
        wr(ADDR_CHAN, 32'hfe);
        sw_conv(32'd1);
        `CHK(last_ch, 4'd14)
        `CHK(last_rng, RNG_U5)
        sw_conv(32'd2);
        `CHK(last_ch, 4'd15)
        `CHK(last_rng, RNG_B10)
        sw_conv(32'd3);
        `CHK(last_ch, 4'd14)
        rd_chk(ADDR_FIFO_DATA, 32'h0000_0001);
        rd_chk(ADDR_FIFO_DATA, 32'h0000_8001);
        rd_chk(ADDR_FIFO_DATA, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h11);
        wr(ADDR_CHAN, 32'h22);
        sw_conv(32'd1);
        `CHK({last_diff, last_ch}, 5'h12)
        rd_chk(ADDR_FIFO_DATA, 32'h0000_0001);
        wr(ADDR_CHAN, 32'h77);
        wr(ADDR_CTRL, 32'h5);
        ext_trig <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_trig <= 1'b0;
        wait_cnt(32'd1);
        `CHK(last_ch, 4'd7)
        wr(ADDR_THRESH, 32'h1);
        wr(ADDR_IRQ_EN, 32'h1);
        @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_EN, 32'h0);
        @(posedge pclk);
        `CHK(irq, 1'b0)
        rd_chk(ADDR_FIFO_DATA, 32'h0000_0001);
        wr(ADDR_IRQ_CLR, 32'h7);
        rd_chk(ADDR_IRQ_STAT, 32'h0);
        wr(ADDR_IRQ_EN, 32'h1);
        @(posedge pclk);
        `CHK(irq, 1'b0)
        n0 = n_conv;
        wr(ADDR_CHAN, 32'h30);
        wr(ADDR_RATE, 32'd7999);
        wr(ADDR_CTRL, 32'hb);
        wait_cnt(32'd4);
        wr(ADDR_CTRL, 32'h0);
        `CHK(n_conv - n0, 4)
        `CHK(last_ch, 4'd3)
        `CHK(irq, 1'b1)
        rd_chk(ADDR_IRQ_STAT, 32'h5);
        rd_chk(ADDR_FIFO_DATA, 32'h0000_0001);
        wr(ADDR_CMD, 32'h2);
        rd_chk(ADDR_FIFO_COUNT, 32'h0);
        rd_chk(ADDR_FIFO_DATA, 32'h0);
        // Source code 3 selects no trigger: a software command must not start anything
        wr(ADDR_CTRL, 32'h7);
        wr(ADDR_CMD, 32'h1);
        repeat (300) @(posedge pclk);
        `CHK(n_conv - n0, 4)
        rd_chk(ADDR_FIFO_COUNT, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire

// File: bench/asfc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module asfc_conv_model (
    input  wire logic        pclk,
    input  wire logic        adc_conv,
    input  wire logic [2:0]  mux_addr,
    input  wire logic        mux_in_sel,
    input  wire logic        adc_diff,
    input  wire logic [1:0]  adc_range,
    input  wire logic [15:0] code,
    output logic             adc_sclk,
    output logic             adc_sdo,
    output logic             adc_frame,
    output logic [3:0]       last_ch,
    output logic [1:0]       last_rng,
    output logic             last_diff,
    output int               n_conv
);
    initial begin
        adc_sclk = 1'b0;
        adc_sdo = 1'b0;
        adc_frame = 1'b0;
        last_ch = 4'h0;
        last_rng = 2'h0;
        last_diff = 1'b0;
        n_conv = 0;
        forever begin
            @(posedge pclk iff adc_conv === 1'b1);
            last_ch = {mux_in_sel, mux_addr};
            last_rng = adc_range;
            last_diff = adc_diff;
            n_conv++;
            // Odd offset keeps the link clock out of phase with pclk
            #13 adc_frame = 1'b1;
            for (int i = 15; i >= 0; i--) begin
                adc_sdo = code[i];
                #40 adc_sclk = 1'b1;
                #40 adc_sclk = 1'b0;
            end
            adc_frame = 1'b0;
            // Released line must not keep the last bit
            adc_sdo = ~adc_sdo;
        end
    end
endmodule
`default_nettype wire

// File: design/asfc_ctrl.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Conversions start from software command, internal rate clock or external trigger pin.
// - Sequencer repeats one channel or walks a first-to-last consecutive range.
// - Single-ended: sixteen channels 0-15 against ground via two 8-way muxes.
// - Differential: eight pairs, inputs 0-7 positive, 8-15 matching negative.
// - Sample mode: exactly one conversion per tick or trigger.
// - Sample mode, single channel: every conversion uses that channel.
// - Sample mode, range: each tick advances one channel, wrapping last to first.
// - Scan mode: each tick converts the whole range back to back.
// - Channels convert strictly one after another, never simultaneously.
// - Results enter a 2048-sample FIFO read out in arrival order.
// - Interrupt raised when stored sample count reaches a nonzero programmed threshold; zero disables it.
// - Input range selectable per channel: 0-5V, 0-10V, +/-5V, +/-10V.
// - Results are 16-bit codes, one step is full scale over 65536.
// - Highest code is full scale minus one step.
// - Bipolar ranges deliver two's complement, -32768 to 32767.
// - Unipolar ranges deliver straight binary, 0 to 65535.
module asfc_ctrl
    import asfc_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      ext_trig,
    input  wire logic                      adc_sclk,
    input  wire logic                      adc_sdo,
    input  wire logic                      adc_frame,
    output logic                           adc_conv,
    output logic [2:0]                     mux_addr,
    output logic                           mux_in_sel,
    output logic                           adc_diff,
    output logic [1:0]                     adc_range,
    output logic                           irq
);
    import asfc_pkg::*;

    function automatic logic [3:0] next_chan(input logic [3:0] ch,
                                             input logic [3:0] first,
                                             input logic [3:0] last);
        next_chan = (ch == last) ? first : ch + 4'h1;
    endfunction

    function automatic logic [1:0] chan_range(input logic [31:0] rng,
                                              input logic [3:0] ch);
        chan_range = rng[{ch, 1'b0} +: 2];
    endfunction

    logic [4:0]             ctrl_ff;
    logic [7:0]             chan_ff;
    logic [31:0]            rate_ff;
    logic [11:0]            thresh_ff;
    logic [31:0]            range_ff;
    logic [2:0]             irq_en_ff;
    logic [2:0]             irq_stat_ff;
    logic [31:0]            prdata_ff;
    logic [31:0]            rate_cnt_ff;
    logic [1:0]             ext_sync_ff;
    logic                   ext_prev_ff;
    asfc_state_t            state_ff;
    logic [3:0]             cur_ch_ff;
    logic                   conv_ff;
    logic [2:0]             mux_addr_ff;
    logic                   mux_in_sel_ff;
    logic                   diff_ff;
    logic [1:0]             range_out_ff;
    logic [CODE_W-1:0]      mem [0:FIFO_DEPTH-1];
    logic [FIFO_AW-1:0]     wr_ptr_ff;
    logic [FIFO_AW-1:0]     rd_ptr_ff;
    logic [11:0]            count_ff;
    logic                   rx_valid;
    logic [CODE_W-1:0]      rx_data;

    asfc_link_rx u_rx (
        .pclk      (pclk),
        .presetn   (presetn),
        .adc_sclk  (adc_sclk),
        .adc_sdo   (adc_sdo),
        .adc_frame (adc_frame),
        .rx_valid  (rx_valid),
        .rx_data   (rx_data)
    );

    // Bus decode; writes land in the access phase, reads are fetched in setup
    wire wr_acc  = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire mapped  = (paddr <= ADDR_IRQ_EN) && (paddr[1:0] == 2'b00);
    wire wr_ctrl   = wr_acc && paddr == ADDR_CTRL;
    wire wr_chan   = wr_acc && paddr == ADDR_CHAN;
    wire wr_rate   = wr_acc && paddr == ADDR_RATE;
    wire wr_thresh = wr_acc && paddr == ADDR_THRESH;
    wire wr_range  = wr_acc && paddr == ADDR_RANGE;
    wire wr_cmd    = wr_acc && paddr == ADDR_CMD;
    wire wr_iclr   = wr_acc && paddr == ADDR_IRQ_CLR;
    wire wr_ien    = wr_acc && paddr == ADDR_IRQ_EN;
    wire fifo_rst  = wr_cmd && pwdata[CMD_FIFO_RST];

    // Configuration fields; differential mode folds channels onto 0-7
    wire       cfg_en   = ctrl_ff[CTRL_EN_BIT];
    wire [1:0] cfg_src  = ctrl_ff[CTRL_SRC_LSB +: 2];
    wire       cfg_scan = ctrl_ff[CTRL_SCAN_BIT];
    wire       cfg_diff = ctrl_ff[CTRL_DIFF_BIT];
    wire [3:0] first_ch = cfg_diff ? {1'b0, chan_ff[2:0]} : chan_ff[3:0];
    wire [3:0] last_ch  = cfg_diff ? {1'b0, chan_ff[6:4]} : chan_ff[7:4];

    // Trigger sources
    wire rate_tick = (rate_cnt_ff == 32'h0);
    wire ext_edge  = ext_sync_ff[1] & ~ext_prev_ff;
    wire sw_trig   = wr_cmd && pwdata[CMD_SWTRIG];
    wire trig_raw  = (cfg_src == SRC_SW)   ? sw_trig :
                     (cfg_src == SRC_RATE) ? rate_tick :
                     (cfg_src == SRC_EXT)  ? ext_edge : 1'b0;
    // Triggers arriving mid-sequence are dropped; software keeps the rate legal
    wire trig      = cfg_en && trig_raw && (state_ff == ST_IDLE);

    // Result formatting: converter sends offset binary, bipolar flips the MSB
    wire bipolar = range_out_ff[1];
    wire [CODE_W-1:0] res_code = {rx_data[CODE_W-1] ^ bipolar, rx_data[CODE_W-2:0]};

    wire fifo_full  = (count_ff == FIFO_FULL);
    wire fifo_empty = (count_ff == 12'h0);
    wire push       = rx_valid && !fifo_full && !fifo_rst;
    wire pop        = rd_setup && paddr == ADDR_FIFO_DATA && !fifo_empty && !fifo_rst;
    wire ovf_event  = rx_valid && fifo_full;
    wire thr_event  = (thresh_ff != 12'h0) && (count_ff >= thresh_ff);
    wire seq_end    = (state_ff == ST_WAIT) && rx_valid && (!cfg_scan || cur_ch_ff == last_ch);
    wire [2:0] irq_set = {seq_end, ovf_event, thr_event};
    // Set wins over a clear in the same cycle
    wire [2:0] nxt_irq_stat = (irq_stat_ff & ~(wr_iclr ? pwdata[2:0] : 3'b000)) | irq_set;

    wire [11:0] nxt_count = count_ff + {11'h0, push} - {11'h0, pop};

    logic [31:0] rd_mux;
    always_comb begin
        unique case (paddr)
            ADDR_CTRL:       rd_mux = {27'h0, ctrl_ff};
            ADDR_CHAN:       rd_mux = {24'h0, chan_ff};
            ADDR_RATE:       rd_mux = rate_ff;
            ADDR_THRESH:     rd_mux = {20'h0, thresh_ff};
            ADDR_RANGE:      rd_mux = range_ff;
            ADDR_FIFO_DATA:  rd_mux = fifo_empty ? 32'h0 : {16'h0, mem[rd_ptr_ff]};
            ADDR_FIFO_COUNT: rd_mux = {20'h0, count_ff};
            ADDR_IRQ_STAT:   rd_mux = {29'h0, irq_stat_ff};
            ADDR_IRQ_EN:     rd_mux = {29'h0, irq_en_ff};
            default:         rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= CTRL_RST;
            chan_ff   <= CHAN_RST;
            rate_ff   <= RATE_RST;
            thresh_ff <= THRESH_RST;
            range_ff  <= RANGE_RST;
            irq_en_ff <= 3'b000;
        end else begin
            if (wr_ctrl)   ctrl_ff   <= pwdata[4:0];
            if (wr_chan)   chan_ff   <= pwdata[7:0];
            if (wr_rate)   rate_ff   <= pwdata;
            if (wr_thresh) thresh_ff <= pwdata[11:0];
            if (wr_range)  range_ff  <= pwdata;
            if (wr_ien)    irq_en_ff <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 3'b000;
            prdata_ff   <= 32'h0;
            rate_cnt_ff <= RATE_RST;
            ext_sync_ff <= 2'b00;
            ext_prev_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (rd_setup) prdata_ff <= rd_mux;
            rate_cnt_ff <= (rate_tick || wr_rate) ? (wr_rate ? pwdata : rate_ff)
                                                  : rate_cnt_ff - 32'h1;
            ext_sync_ff <= {ext_sync_ff[0], ext_trig};
            ext_prev_ff <= ext_sync_ff[1];
        end
    end

    // Sequencer: one conversion in flight at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff      <= ST_IDLE;
            cur_ch_ff     <= 4'h0;
            conv_ff       <= 1'b0;
            mux_addr_ff   <= 3'h0;
            mux_in_sel_ff <= 1'b0;
            diff_ff       <= 1'b0;
            range_out_ff  <= 2'b00;
        end else begin
            conv_ff <= 1'b0;
            if (wr_chan) begin
                cur_ch_ff <= cfg_diff ? {1'b0, pwdata[2:0]} : pwdata[3:0];
            end
            unique case (state_ff)
                ST_IDLE: begin
                    if (trig) state_ff <= ST_SETUP;
                end
                ST_SETUP: begin
                    mux_addr_ff   <= cur_ch_ff[2:0];
                    mux_in_sel_ff <= cfg_diff ? 1'b0 : cur_ch_ff[3];
                    diff_ff       <= cfg_diff;
                    range_out_ff  <= chan_range(range_ff, cur_ch_ff);
                    state_ff      <= ST_CONV;
                end
                ST_CONV: begin
                    conv_ff  <= 1'b1;
                    state_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (rx_valid) begin
                        cur_ch_ff <= next_chan(cur_ch_ff, first_ch, last_ch);
                        state_ff  <= (cfg_scan && cur_ch_ff != last_ch) ? ST_SETUP
                                                                        : ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Result store; the array has no reset so it can map to block memory
    always_ff @(posedge pclk) begin
        if (push) mem[wr_ptr_ff] <= res_code;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= 12'h0;
        end else if (fifo_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= 12'h0;
        end else begin
            if (push) wr_ptr_ff <= wr_ptr_ff + 11'h1;
            if (pop)  rd_ptr_ff <= rd_ptr_ff + 11'h1;
            count_ff <= nxt_count;
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;
    assign adc_conv   = conv_ff;
    assign mux_addr   = mux_addr_ff;
    assign mux_in_sel = mux_in_sel_ff;
    assign adc_diff   = diff_ff;
    assign adc_range  = range_out_ff;
    assign irq        = |(irq_stat_ff & irq_en_ff);

    a_conv_single_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        conv_ff |=> !conv_ff [*2])
        else $error("conversion start not isolated");

    a_sample_one_conv: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_WAIT && rx_valid && !cfg_scan) |=> state_ff == ST_IDLE)
        else $error("sample mode did more than one conversion");

    a_single_chan_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_ff && first_ch == last_ch && $stable(chan_ff)) |-> cur_ch_ff == first_ch)
        else $error("single channel not repeated");

    a_range_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_WAIT && rx_valid && cur_ch_ff == last_ch && !wr_chan)
            |=> cur_ch_ff == first_ch)
        else $error("channel did not wrap to first");

    a_scan_continue: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_WAIT && rx_valid && cfg_scan && cur_ch_ff != last_ch)
            |=> state_ff == ST_SETUP ##2 conv_ff)
        else $error("scan did not continue back to back");

    a_se_input_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_ff && !diff_ff) |-> mux_in_sel_ff == cur_ch_ff[3] && mux_addr_ff == cur_ch_ff[2:0])
        else $error("single-ended mux address wrong");

    a_diff_select: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_ff && diff_ff) |-> !mux_in_sel_ff && !cur_ch_ff[3])
        else $error("differential channel out of 0-7");

    a_range_applied: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_SETUP) |=> range_out_ff == chan_range($past(range_ff), $past(cur_ch_ff)))
        else $error("per-channel range not applied");

    a_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
        count_ff <= FIFO_FULL)
        else $error("fifo count above depth");

    a_ovf_discard: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_valid && fifo_full && !pop && !fifo_rst)
            |=> count_ff == FIFO_FULL && irq_stat_ff[IRQ_OVF])
        else $error("full fifo accepted data or missed overflow");

    a_thresh_flag: assert property (@(posedge pclk) disable iff (!presetn)
        thr_event |=> irq_stat_ff[IRQ_THRESH])
        else $error("threshold flag not set");

    // Checks the stored word at the same write pointer, so a broken write path is caught but a wrong pointer is not
    a_bipolar_fmt: assert property (@(posedge pclk) disable iff (!presetn)
        (push && range_out_ff[1])
            |=> mem[$past(wr_ptr_ff)] == {~$past(rx_data[CODE_W-1]), $past(rx_data[CODE_W-2:0])})
        else $error("bipolar result not stored as two's complement");

    a_unipolar_fmt: assert property (@(posedge pclk) disable iff (!presetn)
        (push && !range_out_ff[1]) |=> mem[$past(wr_ptr_ff)] == $past(rx_data))
        else $error("unipolar result not stored as straight binary");
endmodule
`default_nettype wire

// File: design/asfc_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
module asfc_link_rx
    import asfc_pkg::*;
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         adc_sclk,
    input  wire logic                         adc_sdo,
    input  wire logic                         adc_frame,
    output logic                              rx_valid,
    output logic [asfc_pkg::CODE_W-1:0]       rx_data
);
    import asfc_pkg::*;

    logic [1:0]        sclk_sync_ff;
    logic              sclk_prev_ff;
    logic [1:0]        sdo_sync_ff;
    logic [1:0]        frame_sync_ff;
    logic              frame_prev_ff;
    logic [CODE_W-1:0] shift_ff;
    logic              valid_ff;
    logic [CODE_W-1:0] data_ff;

    // Edges are judged on the second stage only; first stage feeds nothing else
    wire sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
    wire frame_end = frame_prev_ff & ~frame_sync_ff[1];
    wire [CODE_W-1:0] nxt_shift = {shift_ff[CODE_W-2:0], sdo_sync_ff[1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync_ff  <= 2'b00;
            sclk_prev_ff  <= 1'b0;
            sdo_sync_ff   <= 2'b00;
            frame_sync_ff <= 2'b00;
            frame_prev_ff <= 1'b0;
        end else begin
            sclk_sync_ff  <= {sclk_sync_ff[0], adc_sclk};
            sclk_prev_ff  <= sclk_sync_ff[1];
            sdo_sync_ff   <= {sdo_sync_ff[0], adc_sdo};
            frame_sync_ff <= {frame_sync_ff[0], adc_frame};
            frame_prev_ff <= frame_sync_ff[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff <= '0;
            valid_ff <= 1'b0;
            data_ff  <= '0;
        end else begin
            if (sclk_rise && frame_sync_ff[1]) begin
                shift_ff <= nxt_shift;
            end
            valid_ff <= frame_end;
            if (frame_end) begin
                data_ff <= shift_ff;
            end
        end
    end

    assign rx_valid = valid_ff;
    assign rx_data  = data_ff;
endmodule
`default_nettype wire

// File: design/asfc_pkg.sv
package asfc_pkg;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_CHAN       = 8'h04;
    localparam logic [7:0]  ADDR_RATE       = 8'h08;
    localparam logic [7:0]  ADDR_THRESH     = 8'h0c;
    localparam logic [7:0]  ADDR_RANGE      = 8'h10;
    localparam logic [7:0]  ADDR_CMD        = 8'h14;
    localparam logic [7:0]  ADDR_FIFO_DATA  = 8'h18;
    localparam logic [7:0]  ADDR_FIFO_COUNT = 8'h1c;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h20;
    localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h24;
    localparam logic [7:0]  ADDR_IRQ_EN     = 8'h28;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_SRC_LSB  = 1;
    localparam int CTRL_SCAN_BIT = 3;
    localparam int CTRL_DIFF_BIT = 4;
    localparam int CMD_SWTRIG    = 0;
    localparam int CMD_FIFO_RST  = 1;
    localparam int IRQ_THRESH    = 0;
    localparam int IRQ_OVF       = 1;
    localparam int IRQ_DONE      = 2;

    localparam int FIFO_DEPTH    = 2048;
    localparam int FIFO_AW       = 11;
    localparam int CODE_W        = 16;

    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [7:0]  CHAN_RST   = 8'h00;
    localparam logic [31:0] RATE_RST   = 32'h0000_07cf;
    localparam logic [11:0] THRESH_RST = 12'h400;
    localparam logic [31:0] RANGE_RST  = 32'h0000_0000;
    localparam logic [11:0] FIFO_FULL  = 12'h800;

    typedef enum logic [1:0] {
        SRC_SW   = 2'b00,
        SRC_RATE = 2'b01,
        SRC_EXT  = 2'b10,
        SRC_NONE = 2'b11
    } asfc_src_t;

    // Range code: bit 1 set means bipolar
    typedef enum logic [1:0] {
        RNG_U5  = 2'b00,
        RNG_U10 = 2'b01,
        RNG_B5  = 2'b10,
        RNG_B10 = 2'b11
    } asfc_range_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_CONV  = 2'b10,
        ST_WAIT  = 2'b11
    } asfc_state_t;
endpackage
